// *** hw/ccf_top.sv ***
`timescale 1ns/1ns
`include "ccf_defs.svh"

module ccf_top
   import ccf_pkg::*;
#(
   parameter int DEPTH = `CCF_DEPTH,
   parameter int WIDTH = `CCF_WIDTH,
   parameter int TALLY_W = `CCF_TALLY_W,
   parameter bit RST_ASYNC = `CCF_RST_ASYNC,
   parameter bit ECC_EN = `CCF_ECC_EN,
   parameter bit SEP_THRESH = `CCF_SEP_THRESH,
   parameter int AW = $clog2(DEPTH),
   parameter int CW = AW + 1
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic srst,
   input wire logic ce,
   input wire logic write_request,
   input wire logic [WIDTH-1:0] write_word_in,
   input wire logic read_request,
   input wire logic force_single_error,
   input wire logic force_double_error,
   input wire logic [CW-1:0] high_assert_thresh,
   input wire logic [CW-1:0] high_negate_thresh,
   input wire logic [CW-1:0] low_assert_thresh,
   input wire logic [CW-1:0] low_negate_thresh,
   output logic [WIDTH-1:0] read_word_out,
   output ccf_flags_s status,
   output logic [TALLY_W-1:0] stored_word_tally
);

   // ****************************************
   // Types and constants
   // ****************************************
   localparam int MW = 2 * WIDTH + 2;

   typedef struct packed {
      logic [AW-1:0] wptr;
      logic [AW-1:0] rptr;
      logic [CW-1:0] cnt;
      logic [WIDTH-1:0] dout;
      ccf_flags_s flg;
   } ccf_state_s;

   typedef struct packed {
      logic [CW-1:0] hi_a;
      logic [CW-1:0] hi_n;
      logic [CW-1:0] lo_a;
      logic [CW-1:0] lo_n;
   } ccf_thr_s;

   localparam ccf_flags_s FLG_RST = '{
      full: `CCF_RST_FULL,
      empty: `CCF_RST_EMPTY,
      one_slot_left_flag: 1'h0,
      one_word_left_flag: 1'h0,
      high_level_flag: `CCF_RST_HIGH_LVL,
      low_level_flag: `CCF_RST_LOW_LVL,
      valid: 1'h0,
      write_accepted_flag: 1'h0,
      overflow: 1'h0,
      underflow: 1'h0,
      corrected_error_flag: 1'h0,
      uncorrectable_error_flag: 1'h0
   };

   localparam ccf_state_s ST_RST = '{wptr: '0, rptr: '0, cnt: '0, dout: '0, flg: FLG_RST};
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
   localparam logic [CW-1:0] CNT_ONE = CW'(1);

   // ****************************************
   // Elaboration checks
   // ****************************************
   generate
      if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("Depth must be a power of two of at least 4");
      end
      if (WIDTH < 2) begin : g_bad_width
         $error("Word width must be at least 2");
      end
      if (TALLY_W < 1 || TALLY_W > CW) begin : g_bad_tally
         $error("Tally width must be between 1 and the count width");
      end
   endgenerate

   // ****************************************
   // Declarations
   // ****************************************
   ccf_state_s st_ff;
   ccf_state_s nxt_st;
   ccf_thr_s thr_ff;
   logic [MW-1:0] mem [DEPTH];
   logic clr;
   logic wr_ok;
   logic rd_ok;
   logic [CW-1:0] cnt_n;
   logic [CW-1:0] hi_a;
   logic [CW-1:0] hi_n;
   logic [CW-1:0] lo_a;
   logic [CW-1:0] lo_n;
   logic [WIDTH-1:0] flip;
   logic [WIDTH-1:0] enc_a;
   logic [MW-1:0] enc;
   logic [MW-1:0] rword;
   logic [WIDTH-1:0] rd_a;
   logic [WIDTH-1:0] rd_b;
   logic par_a_ok;
   logic par_b_ok;
   logic [WIDTH-1:0] dec_word;
   logic dec_single;
   logic dec_double;

   // ****************************************
   // Request qualification
   // ****************************************
   // Clear from either reset input, seen on the clock
   assign clr = rst | srst;
   // Requests are only taken when the matching flag allows
   assign wr_ok = write_request & ~st_ff.flg.full & ~clr;
   assign rd_ok = read_request & ~st_ff.flg.empty & ~clr;

   // Single shared threshold or separate assert and negate
   assign hi_a = thr_ff.hi_a;
   assign hi_n = SEP_THRESH ? thr_ff.hi_n : thr_ff.hi_a;
   assign lo_a = thr_ff.lo_a;
   assign lo_n = SEP_THRESH ? thr_ff.lo_n : thr_ff.lo_a;

   // ****************************************
   // Error code: two copies plus a parity bit each
   // ****************************************
   // Forced corruption touches copy A only
   assign flip = ECC_EN ? {{(WIDTH-2){1'h0}}, force_double_error, force_single_error | force_double_error} : '0;
   assign enc_a = write_word_in ^ flip;
   assign enc = {^write_word_in, ^write_word_in, write_word_in, enc_a};

   // Decode the word at the head of the queue
   assign rword = mem[st_ff.rptr];
   assign rd_a = rword[WIDTH-1:0];
   assign rd_b = rword[2*WIDTH-1:WIDTH];
   assign par_a_ok = (^rd_a) == rword[2*WIDTH];
   assign par_b_ok = (^rd_b) == rword[2*WIDTH+1];

   // Pick the trustworthy copy and classify the damage
   always_comb begin
      dec_word = rd_a;
      dec_single = 1'h0;
      dec_double = 1'h0;
      if (ECC_EN) begin
         if (rd_a == rd_b) begin
            if (par_a_ok != par_b_ok) begin
               dec_single = 1'h1;
            end else if (!par_a_ok) begin
               dec_double = 1'h1;
            end
         end else if (!par_a_ok && par_b_ok) begin
            dec_word = rd_b;
            dec_single = 1'h1;
         end else if (par_a_ok && !par_b_ok) begin
            dec_single = 1'h1;
         end else begin
            dec_double = 1'h1;
         end
      end
   end

   // ****************************************
   // Next-state logic
   // ****************************************
   // Pointers, count, output word and flags
   always_comb begin
      nxt_st = st_ff;
      // Both operations in one edge leave the count alone
      cnt_n = st_ff.cnt + CW'(wr_ok) - CW'(rd_ok);
      if (wr_ok) begin
         nxt_st.wptr = st_ff.wptr + AW'(1);
      end
      nxt_st.flg.valid = rd_ok;
      nxt_st.flg.corrected_error_flag = rd_ok & dec_single;
      nxt_st.flg.uncorrectable_error_flag = rd_ok & dec_double;
      if (rd_ok) begin
         nxt_st.rptr = st_ff.rptr + AW'(1);
         nxt_st.dout = dec_word;
      end
      nxt_st.cnt = cnt_n;
      nxt_st.flg.full = cnt_n == CNT_FULL;
      nxt_st.flg.empty = cnt_n == '0;
      nxt_st.flg.one_slot_left_flag = cnt_n == CNT_FULL - CNT_ONE;
      nxt_st.flg.one_word_left_flag = cnt_n == CNT_ONE;
      // High level with hysteresis
      if (cnt_n >= hi_a) begin
         nxt_st.flg.high_level_flag = 1'h1;
      end else if (cnt_n < hi_n) begin
         nxt_st.flg.high_level_flag = 1'h0;
      end
      // Low level with hysteresis
      if (cnt_n <= lo_a) begin
         nxt_st.flg.low_level_flag = 1'h1;
      end else if (cnt_n > lo_n) begin
         nxt_st.flg.low_level_flag = 1'h0;
      end
      // One-cycle reports on the previous request
      nxt_st.flg.write_accepted_flag = wr_ok;
      nxt_st.flg.overflow = write_request & st_ff.flg.full & ~clr;
      nxt_st.flg.underflow = read_request & st_ff.flg.empty & ~clr;
      if (clr) begin
         nxt_st = ST_RST;
      end
   end

   // ****************************************
   // State registers
   // ****************************************
   generate
      if (RST_ASYNC) begin : g_async
         // rst acts at once, independent of the clock; srst still waits for a clock edge
         always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
               st_ff <= ST_RST;
            end else if (ce) begin
               st_ff <= nxt_st;
            end
         end
      end else begin : g_sync
         // Clear is taken only at a clock edge
         always_ff @(posedge mclk) begin
            if (ce) begin
               st_ff <= nxt_st;
            end
         end
      end
   endgenerate

   // Thresholds are loaded while any reset is held
   always_ff @(posedge mclk) begin
      if (ce && clr) begin
         thr_ff <= '{hi_a: high_assert_thresh, hi_n: high_negate_thresh,
                     lo_a: low_assert_thresh, lo_n: low_negate_thresh};
      end
   end

   // Storage array, written at the tail
   always_ff @(posedge mclk) begin
      if (ce && wr_ok) begin
         mem[st_ff.wptr] <= enc;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign read_word_out = st_ff.dout;
   assign status = st_ff.flg;
   // Narrow tally keeps the high-order bits
   assign stored_word_tally = st_ff.cnt[CW-1 -: TALLY_W];

   // ****************************************
   // Assertions
   // ****************************************
   a_full_holds: assert property (@(posedge mclk) disable iff (clr)
      (ce && st_ff.flg.full && !read_request) |=> (st_ff.wptr == $past(st_ff.wptr) && st_ff.flg.full))
      else $error("Write while full moved the tail");

   a_empty_holds: assert property (@(posedge mclk) disable iff (clr)
      (ce && st_ff.flg.empty) |=> (st_ff.rptr == $past(st_ff.rptr) && !st_ff.flg.valid))
      else $error("Read while empty moved the head");

   a_write_ack: assert property (@(posedge mclk) disable iff (clr)
      (ce && write_request && !st_ff.flg.full) |=> (st_ff.flg.write_accepted_flag && !st_ff.flg.overflow))
      else $error("Accepted write not acknowledged");

   a_overflow_pulse: assert property (@(posedge mclk) disable iff (clr)
      (ce && write_request && st_ff.flg.full) |=> (st_ff.flg.overflow && !st_ff.flg.write_accepted_flag))
      else $error("Rejected write gave no overflow");

   a_underflow_pulse: assert property (@(posedge mclk) disable iff (clr)
      (ce && read_request && st_ff.flg.empty) |=> (st_ff.flg.underflow && !st_ff.flg.valid))
      else $error("Rejected read gave no underflow");

   a_read_valid: assert property (@(posedge mclk) disable iff (clr)
      (ce && read_request && !st_ff.flg.empty) |=> (st_ff.flg.valid && st_ff.rptr == $past(st_ff.rptr) + AW'(1)))
      else $error("Accepted read gave no valid word");

   a_count_steady: assert property (@(posedge mclk) disable iff (clr)
      (ce && write_request && read_request && !st_ff.flg.full && !st_ff.flg.empty)
      |=> (st_ff.cnt == $past(st_ff.cnt)))
      else $error("Count changed on simultaneous read and write");

   a_one_slot: assert property (@(posedge mclk) disable iff (clr)
      st_ff.flg.one_slot_left_flag == (st_ff.cnt == CNT_FULL - CNT_ONE))
      else $error("One-slot flag disagrees with count");

   a_one_word: assert property (@(posedge mclk) disable iff (clr)
      st_ff.flg.one_word_left_flag == (st_ff.cnt == CNT_ONE && !st_ff.flg.empty))
      else $error("One-word flag disagrees with count");

   a_high_level: assert property (@(posedge mclk) disable iff (clr)
      ((st_ff.cnt >= hi_a) |-> st_ff.flg.high_level_flag) and ((st_ff.cnt < hi_n) |-> !st_ff.flg.high_level_flag))
      else $error("High-level flag wrong for count");

   a_low_level: assert property (@(posedge mclk) disable iff (clr)
      ((st_ff.cnt <= lo_a) |-> st_ff.flg.low_level_flag) and ((st_ff.cnt > lo_n) |-> !st_ff.flg.low_level_flag))
      else $error("Low-level flag wrong for count");

   a_ecc_flags: assert property (@(posedge mclk) disable iff (clr)
      (st_ff.flg.corrected_error_flag || st_ff.flg.uncorrectable_error_flag)
      |-> (st_ff.flg.valid && !(st_ff.flg.corrected_error_flag && st_ff.flg.uncorrectable_error_flag)))
      else $error("Error flag without a read word");

endmodule

// *** hw/ccf_defs.svh ***
// Operation
// - Asynchronous clear resets pointers and output registers without waiting for a clock.
// - Synchronous clear option reinitialises pointers and output registers at a clock edge.
// - Build-time choice of synchronous or asynchronous reset for any memory style.
// - Everything except the asynchronous clear works on the one shared clock.
// - Write request while not full stores the input word at the tail.
// - Writes while full are ignored; contents and pointers stay unchanged.
// - Read request while not empty removes the oldest word onto the output.
// - Reads while empty are ignored without corrupting contents or pointers.
// - Stored-word tally reports occupancy; a narrow tally drops low-order bits.
// - One-slot-left flag is high when exactly one more write fits.
// - High-level flag rises at or above assert level, falls below negate level.
// - High assert threshold sets rise level; high negate threshold sets fall level.
// - Build-time choice of one shared threshold or separate assert and negate thresholds.
// - Thresholds are captured while reset is active; other logic holds them stable.
// - Write-accepted flag is high for one clock after an accepted write.
// - Overflow is high for one clock after a write while full; data kept.
// - One-word-left flag is high when exactly one word remains.
// - Low-level flag rises at or below assert level, falls above negate level.
// - Low assert threshold sets rise level; low negate threshold sets clear level.
// - Valid is high for one clock after an accepted read puts a word on the output.
// - Underflow is high for one clock after a read while empty; no damage.
// - With ECC, corrected-error flag accompanies output data repaired from single-bit error.
// - With ECC, uncorrectable-error flag accompanies output data with a double-bit error.
// - With ECC, force inputs corrupt the stored word with one or two bit errors.
`ifndef CCF_DEFS_SVH
`define CCF_DEFS_SVH

// ****************************************
// Build defaults
// ****************************************
`define CCF_DEPTH 16
`define CCF_WIDTH 8
`define CCF_TALLY_W 5
`define CCF_RST_ASYNC 1'h1
`define CCF_ECC_EN 1'h1
`define CCF_SEP_THRESH 1'h1

// ****************************************
// Flag reset values
// ****************************************
`define CCF_RST_EMPTY 1'h1
`define CCF_RST_FULL 1'h0
`define CCF_RST_LOW_LVL 1'h1
`define CCF_RST_HIGH_LVL 1'h0

`endif

// *** hw/ccf_pkg.sv ***
package ccf_pkg;

   // ****************************************
   // Status flags carried as one group
   // ****************************************
   typedef struct packed {
      logic full;
      logic empty;
      logic one_slot_left_flag;
      logic one_word_left_flag;
      logic high_level_flag;
      logic low_level_flag;
      logic valid;
      logic write_accepted_flag;
      logic overflow;
      logic underflow;
      logic corrected_error_flag;
      logic uncorrectable_error_flag;
   } ccf_flags_s;

endpackage

// *** test/ccf_user_model.sv ***
`timescale 1ns/1ns

// ****************************************
// Writer and reader logic on the shared clock
// ****************************************
module ccf_user_model
   import ccf_pkg::*;
#(
   parameter int CW = 5,
   parameter int WIDTH = 8
) (
   input wire logic mclk,
   output logic write_request,
   output logic [WIDTH-1:0] write_word_in,
   output logic read_request,
   output logic force_single_error,
   output logic force_double_error,
   output logic [CW-1:0] high_assert_thresh,
   output logic [CW-1:0] high_negate_thresh,
   output logic [CW-1:0] low_assert_thresh,
   output logic [CW-1:0] low_negate_thresh
);
   // Thresholds never move, so they are stable through every clear
   assign high_assert_thresh = CW'(5'h0c);
   assign high_negate_thresh = CW'(5'h0a);
   assign low_assert_thresh = CW'(5'h03);
   assign low_negate_thresh = CW'(5'h05);

   // Quiet requests at time zero
   initial begin
      write_request = 1'h0;
      write_word_in = '0;
      read_request = 1'h0;
      force_single_error = 1'h0;
      force_double_error = 1'h0;
   end

   // Requests change only just after a rising edge; idle data toggles
   task automatic drive(input logic wr, input logic [WIDTH-1:0] w, input logic rd, input logic fs, input logic fd);
      @(posedge mclk);
      write_request <= wr;
      write_word_in <= wr ? w : ~write_word_in;
      read_request <= rd;
      force_single_error <= fs;
      force_double_error <= fd;
   endtask
endmodule

// *** test/test_ccf_top.sv ***
`timescale 1ns/1ns
`define CHK(n, x, g) begin compares++; if ((g) !== (x)) begin num_errors++; \
   $display("BAD %s expected %h seen %h", n, x, g); end end

module test_ccf_top
   import ccf_pkg::*;
;
   logic mclk = 1'h0;
   logic rst, srst, ce, wreq, rreq, fs, fd;
   logic [7:0] wword, dout, e_dout;
   logic [4:0] hat, hnt, lat, lnt, tally, e_tally;
   ccf_flags_s st, e;
   logic [9:0] q[$];
   int compares = 0;
   int num_errors = 0;

   // ****************************************
   // Clock, design and far side
   // ****************************************
   always #20 mclk = ~mclk;

   ccf_top DUT (.mclk(mclk), .rst(rst), .srst(srst), .ce(ce), .write_request(wreq), .write_word_in(wword),
      .read_request(rreq), .force_single_error(fs), .force_double_error(fd), .high_assert_thresh(hat),
      .high_negate_thresh(hnt), .low_assert_thresh(lat), .low_negate_thresh(lnt), .read_word_out(dout),
      .status(st), .stored_word_tally(tally));

   ccf_user_model u (.mclk(mclk), .write_request(wreq), .write_word_in(wword), .read_request(rreq),
      .force_single_error(fs), .force_double_error(fd), .high_assert_thresh(hat), .high_negate_thresh(hnt),
      .low_assert_thresh(lat), .low_negate_thresh(lnt));

   // ****************************************
   // Reference model and comparisons
   // ****************************************
   task automatic reset_model();
      q.delete();
      e = '0;
      e.empty = 1'h1;
      e.low_level_flag = 1'h1;
      e_dout = 8'h00;
      e_tally = 5'h00;
   endtask

   task automatic check();
      `CHK("full", e.full, st.full)
      `CHK("empty", e.empty, st.empty)
      `CHK("one_slot", e.one_slot_left_flag, st.one_slot_left_flag)
      `CHK("one_word", e.one_word_left_flag, st.one_word_left_flag)
      `CHK("high_level", e.high_level_flag, st.high_level_flag)
      `CHK("low_level", e.low_level_flag, st.low_level_flag)
      `CHK("valid", e.valid, st.valid)
      `CHK("wr_accepted", e.write_accepted_flag, st.write_accepted_flag)
      `CHK("overflow", e.overflow, st.overflow)
      `CHK("underflow", e.underflow, st.underflow)
      `CHK("corrected", e.corrected_error_flag, st.corrected_error_flag)
      `CHK("uncorrectable", e.uncorrectable_error_flag, st.uncorrectable_error_flag)
      `CHK("read_word", e_dout, dout)
      `CHK("tally", e_tally, tally)
   endtask

   // One request cycle; flags at the sampling edge decide acceptance
   task automatic cyc(input logic en, input logic wr, input logic [7:0] w, input logic rd, input logic f1,
      input logic f2);
      logic [9:0] h;
      int n;
      u.drive(wr, w, rd, f1, f2);
      ce <= en;
      @(negedge mclk);
      check();
      if (en) begin
         e.overflow = wr && e.full;
         e.underflow = rd && e.empty;
         e.write_accepted_flag = wr && !e.full;
         e.valid = rd && !e.empty;
         e.corrected_error_flag = 1'h0;
         e.uncorrectable_error_flag = 1'h0;
         if (e.valid) begin
            h = q.pop_front();
            // A double error leaves the first copy with its two low bits flipped
            e_dout = h[9] ? h[7:0] ^ 8'h03 : h[7:0];
            e.uncorrectable_error_flag = h[9];
            e.corrected_error_flag = h[8] && !h[9];
         end
         if (e.write_accepted_flag) q.push_back({f2, f1, w});
         n = q.size();
         e.full = n == 16;
         e.empty = n == 0;
         e.one_slot_left_flag = n == 15;
         e.one_word_left_flag = n == 1;
         if (n >= 12) e.high_level_flag = 1'h1;
         else if (n < 10) e.high_level_flag = 1'h0;
         if (n <= 3) e.low_level_flag = 1'h1;
         else if (n > 5) e.low_level_flag = 1'h0;
         e_tally = 5'(n);
      end
   endtask

   // Clear held four edges with requests idle
   task automatic clear(input bit use_srst);
      u.drive(1'h0, 8'h00, 1'h0, 1'h0, 1'h0);
      if (use_srst) srst <= 1'h1;
      else rst <= 1'h1;
      ce <= 1'h1;
      repeat (4) @(posedge mclk);
      rst <= 1'h0;
      srst <= 1'h0;
      reset_model();
      @(negedge mclk);
      check();
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Cuts a hang short
   initial begin
      repeat (3000) @(posedge mclk);
      num_errors++;
      $display("BAD run_length expected %h seen %h", 1'h0, 1'h1);
      conclude();
   end

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      rst = 1'h1;
      srst = 1'h0;
      ce = 1'h1;
      clear(1'b0);
      // Fill past full, one frozen cycle on the way
      for (int i = 0; i < 18; i++) cyc(i != 5, 1'h1, 8'(i * 3 + 1), 1'h0, 1'h0, 1'h0);
      $display("end fill");
      for (int i = 0; i < 18; i++) cyc(i != 7, 1'h0, 8'h00, 1'h1, 1'h0, 1'h0);
      $display("end drain");
      // Push and pop together when empty, at full and one below full; push alone while filling
      for (int i = 0; i < 24; i++) cyc(1'h1, 1'h1, 8'(i + 32), i == 0 || i >= 17, 1'h0, 1'h0);
      for (int i = 0; i < 17; i++) cyc(1'h1, 1'h0, 8'h00, 1'h1, 1'h0, 1'h0);
      $display("end both");
      // Error injection on stored words
      cyc(1'h1, 1'h1, 8'h5a, 1'h0, 1'h1, 1'h0);
      cyc(1'h1, 1'h1, 8'ha5, 1'h0, 1'h0, 1'h1);
      cyc(1'h1, 1'h1, 8'h3c, 1'h0, 1'h1, 1'h1);
      cyc(1'h1, 1'h1, 8'hc3, 1'h0, 1'h0, 1'h0);
      for (int i = 0; i < 5; i++) cyc(1'h1, 1'h0, 8'h00, 1'h1, 1'h0, 1'h0);
      $display("end ecc");
      // Synchronous clear in mid-run
      for (int i = 0; i < 3; i++) cyc(1'h1, 1'h1, 8'(i + 96), 1'h0, 1'h0, 1'h0);
      clear(1'b1);
      cyc(1'h1, 1'h1, 8'h77, 1'h0, 1'h0, 1'h0);
      cyc(1'h1, 1'h0, 8'h00, 1'h1, 1'h0, 1'h0);
      cyc(1'h1, 1'h0, 8'h00, 1'h0, 1'h0, 1'h0);
      $display("end sync clear");
      // Asynchronous clear between edges
      for (int i = 0; i < 4; i++) cyc(1'h1, 1'h1, 8'(i + 144), i == 3, 1'h0, 1'h0);
      #5 rst = 1'h1;
      #2 reset_model();
      check();
      clear(1'b0);
      cyc(1'h1, 1'h1, 8'h99, 1'h0, 1'h0, 1'h0);
      cyc(1'h1, 1'h0, 8'h00, 1'h1, 1'h0, 1'h0);
      cyc(1'h1, 1'h0, 8'h00, 1'h0, 1'h0, 1'h0);
      $display("end async clear");
      conclude();
   end
endmodule
